// ==== rtl/pjm_defines.vh ====
// opcode, field and reset-value constants for the jump and move decoder
`ifndef PJM_DEFINES_VH
`define PJM_DEFINES_VH
`define PJM_OP_JT1_LOW 8'h46
`define PJM_OP_JT0_HIGH 8'h36
`define PJM_OP_JT1_HIGH 8'h56
`define PJM_OP_JNZ 8'h96
`define PJM_OP_JZ 8'hC6
`define PJM_OP_JOUT_FULL 8'h86
`define PJM_OP_JTIMER 8'h16
`define PJM_OP_MOV_A_IMM 8'h23
`define PJM_OP_MOV_A_PSW 8'hC7
`define PJM_OP_MOV_A_T 8'h42
`define PJM_OP_MOV_PSW_A 8'hD7
`define PJM_OP_MOV_STS_A 8'h90
`define PJM_OP_MOV_T_A 8'h62
`define PJM_OP_PAGE_READ 8'hA3
`define PJM_OP_OUT_BUF 8'h02
`define PJM_OP_NOP 8'h00
`define PJM_GRP_A_REG 5'h1F
`define PJM_GRP_REG_A 5'h15
`define PJM_GRP_REG_IMM 5'h17
`define PJM_GRP_A_IND 7'h78
`define PJM_GRP_IND_A 7'h50
`define PJM_GRP_IND_IMM 7'h58
`define PJM_GRP_EXP_RD 6'h03
`define PJM_GRP_EXP_WR 6'h0F
`define PJM_EXP_PORT_BASE 3'h4
`define PJM_STS_HI_MSB 7
`define PJM_STS_HI_LSB 4
`define PJM_PC_RST 11'h000
`define PJM_BYTE_RST 8'h00
`endif

// ==== rtl/pjm_core.v ====
// instruction decode and execute for test jumps and data moves
`timescale 1ns/1ns
`default_nettype none
`include "pjm_defines.vh"

module pjm_core (
  input wire clk, // 20 MHz clock
  input wire rst, // synchronous reset, active high
  output reg [10:0] prog_addr_ff, // program memory address
  input wire [7:0] prog_data, // program byte, valid cycle after address
  input wire test_input_zero, // test pin 0, asynchronous
  input wire test_input_one, // test pin 1, asynchronous
  input wire timer_tick, // one-cycle count enable from outside
  input wire timer_irq_en, // timer-overflow interrupt enable
  output reg timer_irq_req_ff, // one-cycle interrupt start pulse
  output reg timer_rollover_flag_ff, // timer flag
  input wire host_out_clear, // host read the output buffer
  output reg host_out_full_flag_ff, // output buffer full flag
  output reg [7:0] host_data_buffer_ff, // output data buffer
  output reg [7:0] host_status_reg_ff, // host status register
  input wire [3:0] host_status_low, // low status bits owned elsewhere
  output reg [2:0] exp_port_ff, // selected expander port number
  output reg [3:0] exp_wdata_ff, // expander write nibble
  output reg exp_wr_ff, // one-cycle expander write strobe
  output reg exp_rd_ff, // one-cycle expander read strobe
  input wire [3:0] exp_rdata, // expander read nibble
  output reg [7:0] acc_ff, // accumulator
  output reg [7:0] program_status_word_ff, // status word
  output reg [7:0] timer_ff // timer/counter
);

  // ------------------------------------------------------------
  // state machine and storage
  // ------------------------------------------------------------
  localparam ST_FETCH = 2'd0;
  localparam ST_DECODE = 2'd1;
  localparam ST_SECOND = 2'd2;
  localparam ST_TABLE = 2'd3;

  reg [1:0] state_ff;
  reg [10:0] pc_ff;
  reg [7:0] op_ff;
  // 64 bytes; indirect pointers keep only their low six bits
  reg [7:0] dmem [0:63];

  // working registers live in data memory; bank from status bit 4
  function [5:0] reg_addr;
    input [2:0] r;
    input bank;
    begin
      reg_addr = bank ? {3'h3, r} : {3'h0, r};
    end
  endfunction

  // ports 4..7 from the two low opcode bits; the add cannot carry out
  function [2:0] exp_port_of;
    input [1:0] sel;
    begin
      exp_port_of = `PJM_EXP_PORT_BASE + {1'b0, sel};
    end
  endfunction

  wire [5:0] wreg_addr = reg_addr(op_ff[2:0], program_status_word_ff[4]);
  wire [5:0] ptr_addr = reg_addr({2'h0, op_ff[0]},
    program_status_word_ff[4]);
  wire [7:0] wreg_val = dmem[wreg_addr];
  wire [5:0] ind_addr = dmem[ptr_addr][5:0];
  wire [7:0] ind_val = dmem[ind_addr];
  // pc has moved past the pad byte; one back is the byte after the opcode
  wire [10:0] pc_back = pc_ff - 11'h001;

  wire two_cycle = (op_ff == `PJM_OP_JT1_LOW) || (op_ff == `PJM_OP_JT0_HIGH)
    || (op_ff == `PJM_OP_JT1_HIGH) || (op_ff == `PJM_OP_JNZ)
    || (op_ff == `PJM_OP_JZ) || (op_ff == `PJM_OP_JOUT_FULL)
    || (op_ff == `PJM_OP_JTIMER) || (op_ff == `PJM_OP_MOV_A_IMM)
    || (op_ff[7:3] == `PJM_GRP_REG_IMM) || (op_ff[7:1] == `PJM_GRP_IND_IMM);

  // ------------------------------------------------------------
  // opcode group decode
  // ------------------------------------------------------------
  wire is_a_reg = (op_ff[7:3] == `PJM_GRP_A_REG);
  wire is_reg_a = (op_ff[7:3] == `PJM_GRP_REG_A);
  wire is_reg_imm = (op_ff[7:3] == `PJM_GRP_REG_IMM);
  wire is_a_ind = (op_ff[7:1] == `PJM_GRP_A_IND);
  wire is_ind_a = (op_ff[7:1] == `PJM_GRP_IND_A);
  wire is_ind_imm = (op_ff[7:1] == `PJM_GRP_IND_IMM);
  wire is_exp_rd = (op_ff[7:2] == `PJM_GRP_EXP_RD);
  wire is_exp_wr = (op_ff[7:2] == `PJM_GRP_EXP_WR);
  wire is_out_buf = (op_ff == `PJM_OP_OUT_BUF);
  wire is_page_rd = (op_ff == `PJM_OP_PAGE_READ);

  // ------------------------------------------------------------
  // test pin synchronisers: change taken when stages 2 and 3 agree
  // ------------------------------------------------------------
  wire [1:0] pin_raw = {test_input_one, test_input_zero};
  wire [1:0] pin_clean;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pin
      reg [2:0] sync_ff;
      reg clean_ff;
      always @(posedge clk) begin
        if (rst) begin
          sync_ff <= 3'h0;
          clean_ff <= 1'b0;
        end else begin
          sync_ff <= {sync_ff[1:0], pin_raw[g]};
          // a lone glitch never reaches the jump condition
          if (sync_ff[1] == sync_ff[2]) clean_ff <= sync_ff[2];
        end
      end
      assign pin_clean[g] = clean_ff;
    end
  endgenerate
  wire t0_ok = pin_clean[0];
  wire t1_ok = pin_clean[1];

  // ------------------------------------------------------------
  // jump condition
  // ------------------------------------------------------------
  // pins are judged from the filtered copies, never the raw inputs
  reg take_jump;
  always @* begin
    case (op_ff)
      `PJM_OP_JT1_LOW: take_jump = !t1_ok;
      `PJM_OP_JT0_HIGH: take_jump = t0_ok;
      `PJM_OP_JT1_HIGH: take_jump = t1_ok;
      `PJM_OP_JNZ: take_jump = |acc_ff;
      `PJM_OP_JZ: take_jump = ~|acc_ff;
      `PJM_OP_JOUT_FULL: take_jump = host_out_full_flag_ff;
      `PJM_OP_JTIMER: take_jump = timer_rollover_flag_ff;
      default: take_jump = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // execute slots
  // ------------------------------------------------------------
  // executes this cycle (output-buffer write and timer load in decode, everything else in second)
  // buffer write and timer load finish in the next decode slot while acc is steady
  wire exec1 = (state_ff == ST_DECODE);
  wire exec2 = (state_ff == ST_SECOND);
  wire out_buf_exec = exec1 && is_out_buf;
  wire jtf_exec = exec2 && (op_ff == `PJM_OP_JTIMER);
  wire [7:0] timer_inc = timer_ff + 8'h01;
  wire timer_load = exec1 && (op_ff == `PJM_OP_MOV_T_A);
  wire rollover = timer_tick && !timer_load && (timer_inc == 8'h00);

  // ------------------------------------------------------------
  // timer and flag: rollover set wins over the clearing jump
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      timer_ff <= `PJM_BYTE_RST;
      timer_rollover_flag_ff <= 1'b0;
      timer_irq_req_ff <= 1'b0;
    end else begin
      timer_irq_req_ff <= rollover && timer_irq_en;
      if (timer_load) timer_ff <= acc_ff;
      else if (timer_tick) timer_ff <= timer_inc;
      if (rollover) timer_rollover_flag_ff <= 1'b1;
      else if (jtf_exec) timer_rollover_flag_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // sequencer and datapath
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_FETCH;
      pc_ff <= `PJM_PC_RST;
      prog_addr_ff <= `PJM_PC_RST;
      op_ff <= `PJM_OP_NOP;
      acc_ff <= `PJM_BYTE_RST;
      program_status_word_ff <= `PJM_BYTE_RST;
      host_status_reg_ff <= `PJM_BYTE_RST;
      host_data_buffer_ff <= `PJM_BYTE_RST;
      host_out_full_flag_ff <= 1'b0;
      exp_port_ff <= `PJM_EXP_PORT_BASE;
      exp_wdata_ff <= 4'h0;
      exp_wr_ff <= 1'b0;
      exp_rd_ff <= 1'b0;
    end else begin
      exp_wr_ff <= 1'b0;
      exp_rd_ff <= 1'b0;
      host_status_reg_ff[3:0] <= host_status_low;
      // host read clears, our write sets; the set wins
      if (out_buf_exec) begin
        host_data_buffer_ff <= acc_ff;
        host_out_full_flag_ff <= 1'b1;
      end else if (host_out_clear) begin
        host_out_full_flag_ff <= 1'b0;
      end
      case (state_ff)
        ST_FETCH: begin
          state_ff <= ST_DECODE;
        end
        ST_DECODE: begin
          op_ff <= prog_data;
          state_ff <= ST_SECOND;
          if (two_cycle_in(prog_data)) begin
            pc_ff <= pc_ff + 11'h002;
            prog_addr_ff <= pc_ff + 11'h001;
          end else begin
            pc_ff <= pc_ff + 11'h001;
            prog_addr_ff <= pc_ff + 11'h001;
          end
        end
        ST_SECOND: begin
          state_ff <= ST_FETCH;
          prog_addr_ff <= pc_ff;
          exec_op(prog_data);
        end
        ST_TABLE: begin
          acc_ff <= prog_data;
          prog_addr_ff <= pc_ff;
          state_ff <= ST_DECODE;
        end
        default: state_ff <= ST_FETCH;
      endcase
    end
  end

  // ------------------------------------------------------------
  // decode and execute helpers
  // ------------------------------------------------------------
  // every opcode counted as two bytes; the program-bus byte is not decoded
  function two_cycle_in;
    input [7:0] o;
    begin
      two_cycle_in = 1'b1;
    end
  endfunction

  // second-cycle execution; operand is the byte after the opcode
  task exec_op;
    input [7:0] operand;
    begin
      if (two_cycle && take_jump) begin
        pc_ff <= {pc_ff[10:8], operand};
        prog_addr_ff <= {pc_ff[10:8], operand};
      end
      case (op_ff)
        `PJM_OP_MOV_A_IMM: acc_ff <= operand;
        `PJM_OP_MOV_A_PSW: acc_ff <= program_status_word_ff;
        `PJM_OP_MOV_A_T: acc_ff <= timer_ff;
        `PJM_OP_MOV_PSW_A: program_status_word_ff <= acc_ff;
        `PJM_OP_MOV_STS_A: host_status_reg_ff[`PJM_STS_HI_MSB:
          `PJM_STS_HI_LSB] <= acc_ff[7:4];
        `PJM_OP_PAGE_READ: begin
          // page of the byte after the opcode: only offset 255 moves on
          prog_addr_ff <= {pc_back[10:8], acc_ff};
          state_ff <= ST_TABLE;
        end
        default: begin
        end
      endcase
      if (is_a_reg) acc_ff <= wreg_val;
      if (is_reg_a) dmem[wreg_addr] <= acc_ff;
      if (is_reg_imm) dmem[wreg_addr] <= operand;
      if (is_a_ind) acc_ff <= ind_val;
      if (is_ind_a) dmem[ind_addr] <= acc_ff;
      if (is_ind_imm) dmem[ind_addr] <= operand;
      // expander traffic: one strobe per execute, port held afterwards
      if (is_exp_rd) begin
        exp_port_ff <= exp_port_of(op_ff[1:0]);
        exp_rd_ff <= 1'b1;
        acc_ff <= {4'h0, exp_rdata};
      end
      if (is_exp_wr) begin
        exp_port_ff <= exp_port_of(op_ff[1:0]);
        exp_wdata_ff <= acc_ff[3:0];
        exp_wr_ff <= 1'b1;
      end
    end
  endtask

endmodule
`default_nettype wire

// ==== sim/pjm_core_chk.sv ====
// port-level assertions for the jump and move decoder
`timescale 1ns/1ns
`default_nettype none
module pjm_core_chk (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic timer_irq_en, // irq enable
  input wire logic timer_tick, // count enable
  input wire logic host_out_clear, // host read
  input wire logic [3:0] host_status_low, // low status
  input wire logic [7:0] host_status_reg_ff, // status reg
  input wire logic host_out_full_flag_ff, // out full
  input wire logic timer_irq_req_ff, // irq pulse
  input wire logic timer_rollover_flag_ff, // timer flag
  input wire logic [7:0] timer_ff, // timer
  input wire logic [7:0] acc_ff, // accumulator
  input wire logic [2:0] exp_port_ff, // port number
  input wire logic [3:0] exp_wdata_ff, // write nibble
  input wire logic exp_wr_ff, // write strobe
  input wire logic exp_rd_ff // read strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wrap_sets_flag:
    assert property ($past(timer_tick) && $past(timer_ff) == 8'hFF
      && timer_ff == 8'h00
      |-> ##[0:1] timer_rollover_flag_ff) else $error("wrap kept flag low");
  a_irq_on_wrap:
    assert property ($rose(timer_rollover_flag_ff) && timer_irq_en
      |-> ##[0:1] timer_irq_req_ff) else $error("no irq on wrap");
  a_irq_needs_en:
    assert property (timer_irq_req_ff |-> $past(timer_irq_en))
      else $error("irq while disabled");
  a_out_full_holds:
    assert property (host_out_full_flag_ff && !host_out_clear
      |=> host_out_full_flag_ff) else $error("out full lost");
  a_port_range:
    assert property (exp_wr_ff || exp_rd_ff |-> exp_port_ff[2])
      else $error("port below 4");
  a_strobe_excl:
    assert property (!(exp_wr_ff && exp_rd_ff)) else $error("both strobes");
  a_read_clears_hi:
    assert property (exp_rd_ff |-> ##[0:2] acc_ff[7:4] == 4'h0)
      else $error("high nibble kept");
  a_write_nibble:
    assert property (exp_wr_ff |-> exp_wdata_ff == acc_ff[3:0])
      else $error("bad write nibble");
  a_status_low:
    assert property (1'b1 |=> host_status_reg_ff[3:0] ==
      $past(host_status_low)) else $error("low status changed");
endmodule
bind pjm_core pjm_core_chk u_chk (.clk(clk), .rst(rst),
  .timer_irq_en(timer_irq_en), .host_out_clear(host_out_clear),
  .timer_tick(timer_tick),
  .host_status_low(host_status_low), .acc_ff(acc_ff),
  .host_status_reg_ff(host_status_reg_ff), .timer_ff(timer_ff),
  .host_out_full_flag_ff(host_out_full_flag_ff),
  .timer_irq_req_ff(timer_irq_req_ff), .exp_rd_ff(exp_rd_ff),
  .timer_rollover_flag_ff(timer_rollover_flag_ff),
  .exp_port_ff(exp_port_ff), .exp_wdata_ff(exp_wdata_ff),
  .exp_wr_ff(exp_wr_ff));
`default_nettype wire

// ==== sim/pjm_core_bench.sv ====
// self-checking bench for the jump and move decoder
`timescale 1ns/1ns
`default_nettype none
module pjm_core_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] prog_data = 8'h00;
  reg t0 = 1'b0, t1 = 1'b0, tick = 1'b0;
  wire [10:0] pa;
  wire irq, tflag, ofull, ewr, erd;
  wire [7:0] dbuf, sts, acc, program_status_word, tmr;
  wire [2:0] eport;
  wire [3:0] ewd;
  reg [7:0] rom [0:2047];
  integer failures = 0, n_compared = 0, cyc = 0, pw, i;
  pjm_core dut (.clk(clk), .rst(rst), .prog_addr_ff(pa),
    .prog_data(prog_data), .test_input_zero(t0), .test_input_one(t1),
    .timer_tick(tick), .timer_irq_en(1'b1), .timer_irq_req_ff(irq),
    .timer_rollover_flag_ff(tflag), .host_out_clear(1'b0),
    .host_out_full_flag_ff(ofull), .host_data_buffer_ff(dbuf),
    .host_status_reg_ff(sts), .host_status_low(4'hA),
    .exp_port_ff(eport), .exp_wdata_ff(ewd), .exp_wr_ff(ewr),
    .exp_rd_ff(erd), .exp_rdata(4'h9), .acc_ff(acc),
    .program_status_word_ff(program_status_word), .timer_ff(tmr));
  initial forever #25 clk = ~clk;
  // program memory answers one half cycle after the address moves
  always @(negedge clk) prog_data <= rom[pa];
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      summarize;
    end
  end
  task summarize;
    begin
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task emit(input [7:0] op, input [7:0] arg);
    begin
      rom[pw] = op;
      rom[pw + 1] = arg;
      pw = pw + 2;
    end
  endtask
  task start;
    begin
      for (i = 0; i < 2048; i = i + 1) rom[i] = 8'h00;
      pw = 0;
    end
  endtask
  task run(input integer n);
    begin
      @(negedge clk);
      rst = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (n) @(negedge clk);
    end
  endtask
  // both paths end in a self loop so the later code never runs
  task jump_case(input [7:0] a0, a1, b0, b1, op, input tk,
                 input [1:0] pins, input tm);
    begin
      start;
      emit(a0, a1);
      emit(b0, b1);
      // pad gives a delayed timer load time to roll over before the jump
      emit(8'h00, 8'h00);
      emit(op, 8'h40);
      emit(8'h23, 8'hEE);
      emit(8'h96, 8'h0A);
      pw = 8'h40;
      emit(8'h23, 8'h77);
      emit(8'h96, 8'h42);
      {t1, t0} = pins;
      tick = tm;
      run(60);
      check(acc, tk ? 8'h77 : 8'hEE);
      check({7'h00, tflag}, 8'h00);
    end
  endtask
  task moves_case;
    begin
      start;
      emit(8'h23, 8'h5A);
      emit(8'hAB, 8'h00);
      emit(8'h23, 8'h00);
      emit(8'hFB, 8'h00);
      emit(8'h90, 8'h00);
      emit(8'h62, 8'h00);
      emit(8'hB8, 8'h14);
      emit(8'hB0, 8'hC3);
      emit(8'hF0, 8'h00);
      emit(8'h3D, 8'h00);
      emit(8'h0E, 8'h00);
      emit(8'hD7, 8'h00);
      emit(8'h23, 8'h00);
      emit(8'hC7, 8'h00);
      tick = 1'b0;
      run(70);
      check(acc, 8'h09);
      check(program_status_word, 8'h09);
      check(tmr, 8'h5A);
      check(sts, 8'h5A);
      check({5'h00, eport}, 8'h06);
      check({4'h0, ewd}, 8'h03);
    end
  endtask
  task page_edge_case;
    begin
      start;
      emit(8'h23, 8'h00);
      emit(8'hC6, 8'hFF);
      rom[255] = 8'hA3;
      rom[256] = 8'hC5;
      run(40);
      check(acc, 8'hC5);
      start;
      emit(8'h23, 8'h00);
      emit(8'hC6, 8'hFE);
      rom[254] = 8'hA3;
      run(40);
      check(acc, 8'h23);
    end
  endtask
  initial begin
    moves_case;
    page_edge_case;
    jump_case(8'h23, 8'h00, 8'h00, 8'h00, 8'hC6, 1, 0, 0);
    jump_case(8'h23, 8'h01, 8'h00, 8'h00, 8'hC6, 0, 0, 0);
    jump_case(8'h23, 8'h80, 8'h00, 8'h00, 8'h96, 1, 0, 0);
    jump_case(8'h23, 8'h00, 8'h00, 8'h00, 8'h96, 0, 0, 0);
    jump_case(8'h23, 8'h3C, 8'h02, 8'h00, 8'h86, 1, 0, 0);
    check(dbuf, 8'h3C);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h86, 0, 0, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h36, 1, 1, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h36, 0, 2, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h56, 1, 2, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h56, 0, 1, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h46, 1, 1, 0);
    jump_case(8'h00, 8'h00, 8'h00, 8'h00, 8'h46, 0, 2, 0);
    jump_case(8'h23, 8'hFF, 8'h62, 8'h00, 8'h16, 1, 0, 1);
    jump_case(8'h23, 8'hFF, 8'h62, 8'h00, 8'h16, 0, 0, 0);
    summarize;
  end
endmodule
`default_nettype wire
